// >>> logic/ddmr_consts.vh
// Constants for the DDR3 mode register decode block: field positions, codes and timing counts.
// Assumes inclusion by bare name from the design files of this block.
`ifndef DDMR_CONSTS_VH
`define DDMR_CONSTS_VH
`define DDMR_ADDR_W        18
`define DDMR_BA_BASE       3'h0
`define DDMR_BA_SECOND     3'h1
`define DDMR_BL_LSB        0
`define DDMR_BL_FIXED8     2'h0
`define DDMR_BL_OTF        2'h1
`define DDMR_BL_FIXED4     2'h2
`define DDMR_BT_BIT        3
`define DDMR_CL_LSB        4
`define DDMR_CL_LOW_BIT    2
`define DDMR_DLL_RST_BIT   8
`define DDMR_WR_LSB        9
`define DDMR_PD_BIT        12
`define DDMR_CHOP_ABIT     12
`define DDMR_DLL_DIS_BIT   0
`define DDMR_LEVEL_BIT     7
`define DDMR_QOFF_BIT      12
`define DDMR_RTT_B0        2
`define DDMR_RTT_B1        6
`define DDMR_RTT_B2        9
`define DDMR_BASE_RSV_MASK 18'h26080
`define DDMR_SEC_RSV_MASK  18'h26500
`define DDMR_DLL_LOCK_CYC  512
`define DDMR_BEATS         8
`endif

// >>> logic/ddmr_order.v
// Beat ordering: maps start column and beat index to the column offset of that beat.
// Assumes inputs come from the same clock domain; purely combinational.
`timescale 1ns/1ps
module ddmr_order (
   input  wire [2:0] start_col_i,
   input  wire [2:0] beat_i,
   input  wire       interleave_i,
   input  wire       chop_i,
   input  wire       is_write_i,
   output reg  [2:0] col_o
);
   // Writes ignore the low bits; chopped writes keep bit 2 only, full writes run 0..7.
   always @* begin
      if (is_write_i) begin
         col_o = chop_i ? {start_col_i[2], beat_i[1:0]} : beat_i;
      end else if (interleave_i) begin
         col_o = start_col_i ^ beat_i;
      end else begin
         // Rotate inside the starting nibble, then the other nibble; wrap stays in block.
         col_o = {start_col_i[2] ^ beat_i[2], start_col_i[1:0] + beat_i[1:0]};
      end
   end
endmodule // ddmr_order

// >>> logic/ddmr_dll.v
// DLL control: enable state, reset pulse and lock counting for the mode register block.
// Assumes a single clock and control pulses from the same domain.
`timescale 1ns/1ps
`include "ddmr_consts.vh"
module ddmr_dll #(
   parameter LOCK_CYC = `DDMR_DLL_LOCK_CYC
) (
   input  wire clk_i,
   input  wire reset_i,
   input  wire dll_enable_i,
   input  wire dll_reset_i,
   input  wire sr_enter_i,
   input  wire sr_exit_i,
   input  wire pd_enter_i,
   input  wire pd_exit_i,
   input  wire pd_keep_i,
   output wire dll_running_o,
   output wire dll_locked_o
);
   reg        sr_q;
   reg        pd_q;
   reg        sr_restart_q;
   reg [9:0]  lock_cnt_q;
   reg        locked_q;
   wire       restart;
   // Self refresh stops a running DLL; exit restarts it only if it was enabled.
   assign restart = dll_reset_i | (sr_exit_i & sr_restart_q);
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sr_q         <= 1'b0;
         pd_q         <= 1'b0;
         sr_restart_q <= 1'b0;
      end else begin
         if (sr_enter_i) begin
            sr_q         <= 1'b1;
            sr_restart_q <= dll_enable_i;
         end else if (sr_exit_i) begin
            sr_q <= 1'b0;
         end
         if (pd_enter_i) begin
            pd_q <= 1'b1;
         end else if (pd_exit_i) begin
            pd_q <= 1'b0;
         end
      end
   end
   // Precharge power-down stops the DLL unless the keep bit is set.
   assign dll_running_o = dll_enable_i & ~sr_q & ~(pd_q & ~pd_keep_i);
   // Lock counter restarts on each DLL reset; reads are not blocked, only flagged.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         lock_cnt_q <= 10'h000;
         locked_q   <= 1'b0;
      end else if (restart | ~dll_running_o) begin
         lock_cnt_q <= 10'h000;
         locked_q   <= 1'b0;
      end else if (!locked_q) begin
         if (lock_cnt_q == LOCK_CYC[9:0] - 10'h001) begin
            locked_q <= 1'b1;
         end
         lock_cnt_q <= lock_cnt_q + 10'h001;
      end
   end
   assign dll_locked_o = locked_q;
endmodule // ddmr_dll

// >>> logic/ddmr_mode_regs.v
// Operation
// - Burst field 00 fixed eight, 01 per command, 10 fixed four-beat chop.
// - Per-command mode: chop address bit low gives four beats, high eight.
// - Bursts wrap inside an aligned block of four or eight columns.
// - One burst length setting serves both reads and writes.
// - Base register bit 3 picks sequential or interleaved ordering.
// - Reads rotate within nibble sequentially, or XOR start with beat interleaved.
// - Chopped reads drive four beats then tri-state data and strobe four slots.
// - Writes ignore low start bits; chop uses bit 2, eight-beat runs 0..7.
// - Chopped bursts start internally at the same time as eight-beat bursts.
// - Writing DLL reset bit starts reset; the bit then clears itself.
// - Write recovery from bits 11..9: 5, 6, 7, 8, 10 or 12 cycles.
// - Bit 12 zero stops DLL in precharge power-down; one keeps it running.
// - CAS latency 5 to 14 whole cycles from the latency field.
// - First read data appears CAS latency cycles after the internal read.
// - Second register holds until rewritten or reset; array untouched.
// - Leveling with output disable allows all terminations, else write-legal only.
// - Second register bit 0 clear enables DLL, set disables it; enable is followed by a reset.
// - Self refresh stops an enabled DLL, exit re-enables and resets it.
// - A DLL disabled before self refresh stays disabled after exit.
// - Output disable bit tri-states all data and strobe outputs.
// Top of the mode register block: captures mode-set commands, decodes fields, sequences bursts.
// Assumes a decoded command stream on clk_i (the memory clock) with the reset already synchronous to it.
`timescale 1ns/1ps
`include "ddmr_consts.vh"
module ddmr_mode_regs #(
   parameter COL_W    = 10,
   parameter LOCK_CYC = `DDMR_DLL_LOCK_CYC
) (
   input  wire                    clk_i,
   input  wire                    reset_i,
   input  wire                    mrs_i,
   input  wire [2:0]              bank_addr_i,
   input  wire [`DDMR_ADDR_W-1:0] addr_i,
   input  wire                    read_i,
   input  wire                    write_i,
   input  wire [COL_W-1:0]        col_i,
   input  wire                    sr_enter_i,
   input  wire                    sr_exit_i,
   input  wire                    pd_enter_i,
   input  wire                    pd_exit_i,
   output reg  [`DDMR_ADDR_W-1:0] base_mode_register_o,
   output reg  [`DDMR_ADDR_W-1:0] second_mode_register_o,
   output reg  [3:0]              cas_read_latency_o,
   output reg  [3:0]              write_recovery_o,
   output wire                    burst_order_select_o,
   output wire                    powerdown_dll_keep_o,
   output wire                    dll_running_o,
   output wire                    dll_locked_o,
   output wire                    dll_reset_pulse_o,
   output reg                     rtt_allowed_o,
   output reg                     mode_error_o,
   output reg                     beat_valid_o,
   output reg                     beat_is_write_o,
   output reg  [COL_W-1:0]        beat_col_o,
   output reg                     dq_oe_o,
   output reg                     dqs_oe_o,
   output reg                     burst_busy_o
);
   localparam ST_IDLE  = 2'h0;
   localparam ST_WAIT  = 2'h1;
   localparam ST_BURST = 2'h2;

   reg  [1:0]       state_q;
   reg  [3:0]       wait_q;
   reg  [2:0]       beat_q;
   reg              chop_q;
   reg              wr_q;
   reg  [COL_W-1:0] col_q;
   reg              dll_rst_q;
   reg              chop_now;
   wire [2:0]       ord_col;
   wire [1:0]       bl_field;
   wire [2:0]       cl_field;
   wire [2:0]       wr_field;
   wire [2:0]       rtt_field;
   wire             qoff;
   wire             level;

   assign bl_field  = base_mode_register_o[`DDMR_BL_LSB+1:`DDMR_BL_LSB];
   assign cl_field  = base_mode_register_o[`DDMR_CL_LSB+2:`DDMR_CL_LSB];
   assign wr_field  = base_mode_register_o[`DDMR_WR_LSB+2:`DDMR_WR_LSB];
   assign qoff      = second_mode_register_o[`DDMR_QOFF_BIT];
   assign level     = second_mode_register_o[`DDMR_LEVEL_BIT];
   assign rtt_field = {second_mode_register_o[`DDMR_RTT_B2], second_mode_register_o[`DDMR_RTT_B1],
                       second_mode_register_o[`DDMR_RTT_B0]};
   assign burst_order_select_o = base_mode_register_o[`DDMR_BT_BIT];
   assign powerdown_dll_keep_o = base_mode_register_o[`DDMR_PD_BIT];
   assign dll_reset_pulse_o    = dll_rst_q;

   // Mode-set capture; the DLL reset bit is never stored, so it reads back cleared.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         base_mode_register_o   <= {`DDMR_ADDR_W{1'b0}};
         second_mode_register_o <= {`DDMR_ADDR_W{1'b0}};
         dll_rst_q              <= 1'b0;
      end else begin
         dll_rst_q <= 1'b0;
         if (mrs_i && bank_addr_i == `DDMR_BA_BASE) begin
            base_mode_register_o <= addr_i & ~(`DDMR_ADDR_W'h1 << `DDMR_DLL_RST_BIT);
            dll_rst_q            <= addr_i[`DDMR_DLL_RST_BIT];
         end else if (mrs_i && bank_addr_i == `DDMR_BA_SECOND) begin
            second_mode_register_o <= addr_i;
         end
      end
   end

   // CAS latency: codes 1..7 with bit 2 clear give 5..11, codes 0..2 with bit 2 set give 12..14.
   // Every other combination is reserved and decodes to 0, so mode_error_o can flag it.
   always @* begin
      case ({cl_field, base_mode_register_o[`DDMR_CL_LOW_BIT]})
         4'h1:    cas_read_latency_o = 4'hc;
         4'h3:    cas_read_latency_o = 4'hd;
         4'h5:    cas_read_latency_o = 4'he;
         4'h2:    cas_read_latency_o = 4'h5;
         4'h4:    cas_read_latency_o = 4'h6;
         4'h6:    cas_read_latency_o = 4'h7;
         4'h8:    cas_read_latency_o = 4'h8;
         4'ha:    cas_read_latency_o = 4'h9;
         4'hc:    cas_read_latency_o = 4'ha;
         4'he:    cas_read_latency_o = 4'hb;
         default: cas_read_latency_o = 4'h0;
      endcase
   end

   // Write recovery code table; code 0 stands for the longest supported value here.
   always @* begin
      case (wr_field)
         3'h1:    write_recovery_o = 4'h5;
         3'h2:    write_recovery_o = 4'h6;
         3'h3:    write_recovery_o = 4'h7;
         3'h4:    write_recovery_o = 4'h8;
         3'h5:    write_recovery_o = 4'ha;
         3'h6:    write_recovery_o = 4'hc;
         default: write_recovery_o = 4'hc;
      endcase
   end

   // Termination legality while leveling: with outputs on only write-legal values (0..3).
   always @* begin
      if (level && !qoff) begin
         rtt_allowed_o = (rtt_field <= 3'h3);
      end else begin
         rtt_allowed_o = (rtt_field <= 3'h5);
      end
   end

   // Flags settings the block cannot honour; purely informative, nothing is blocked.
   always @* begin
      mode_error_o = (bl_field == 2'h3) | (cas_read_latency_o == 4'h0) | ~rtt_allowed_o |
                     (wr_field == 3'h7) |
                     |(base_mode_register_o & `DDMR_BASE_RSV_MASK) |
                     |(second_mode_register_o & `DDMR_SEC_RSV_MASK);
   end

   // Chop decision at command time; the same setting serves reads and writes.
   always @* begin
      case (bl_field)
         `DDMR_BL_FIXED8: chop_now = 1'b0;
         `DDMR_BL_OTF:    chop_now = ~col_i[`DDMR_CHOP_ABIT % COL_W] ;
         `DDMR_BL_FIXED4: chop_now = 1'b1;
         default:         chop_now = 1'b0;
      endcase
   end

   ddmr_order u_order (
      .start_col_i  (col_q[2:0]),
      .beat_i       (beat_q),
      .interleave_i (burst_order_select_o),
      .chop_i       (chop_q),
      .is_write_i   (wr_q),
      .col_o        (ord_col)
   );

   // Burst sequencer: the latency wait is the same for chop and full bursts.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         wait_q  <= 4'h0;
         beat_q  <= 3'h0;
         chop_q  <= 1'b0;
         wr_q    <= 1'b0;
         col_q   <= {COL_W{1'b0}};
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (read_i || write_i) begin
                  chop_q  <= chop_now;
                  wr_q    <= write_i & ~read_i;
                  col_q   <= col_i;
                  beat_q  <= 3'h0;
                  wait_q  <= cas_read_latency_o - 4'h1;
                  state_q <= (cas_read_latency_o > 4'h1) ? ST_WAIT : ST_BURST;
               end
            end
            ST_WAIT: begin
               wait_q <= wait_q - 4'h1;
               if (wait_q == 4'h1) begin
                  state_q <= ST_BURST;
               end
            end
            ST_BURST: begin
               beat_q <= beat_q + 3'h1;
               if (beat_q == 3'h7) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Beat outputs: registered; chopped bursts keep the slot count but drive only four.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         beat_valid_o    <= 1'b0;
         beat_is_write_o <= 1'b0;
         beat_col_o      <= {COL_W{1'b0}};
         dq_oe_o         <= 1'b0;
         dqs_oe_o        <= 1'b0;
         burst_busy_o    <= 1'b0;
      end else begin
         burst_busy_o    <= (state_q != ST_IDLE);
         beat_is_write_o <= wr_q;
         if (state_q == ST_BURST && !(chop_q && beat_q[2])) begin
            beat_valid_o <= 1'b1;
            beat_col_o   <= {col_q[COL_W-1:3], ord_col};
            dq_oe_o      <= ~wr_q & ~qoff;
            dqs_oe_o     <= ~wr_q & ~qoff;
         end else begin
            beat_valid_o <= 1'b0;
            dq_oe_o      <= 1'b0;
            dqs_oe_o     <= 1'b0;
         end
      end
   end

   ddmr_dll #(
      .LOCK_CYC (LOCK_CYC)
   ) u_dll (
      .clk_i         (clk_i),
      .reset_i       (reset_i),
      .dll_enable_i  (~second_mode_register_o[`DDMR_DLL_DIS_BIT]),
      .dll_reset_i   (dll_rst_q),
      .sr_enter_i    (sr_enter_i),
      .sr_exit_i     (sr_exit_i),
      .pd_enter_i    (pd_enter_i),
      .pd_exit_i     (pd_exit_i),
      .pd_keep_i     (powerdown_dll_keep_o),
      .dll_running_o (dll_running_o),
      .dll_locked_o  (dll_locked_o)
   );
endmodule // ddmr_mode_regs

// >>> verif/ddmr_chk.sv
// Checker for the mode register block: capture, decode and beat output relations.
// Assumes it is bound onto ddmr_mode_regs and sees only that module's ports.
`timescale 1ns/1ps
module ddmr_chk (
   input wire        clk_i,
   input wire        reset_i,
   input wire        mrs_i,
   input wire [2:0]  bank_addr_i,
   input wire [17:0] addr_i,
   input wire        read_i,
   input wire        write_i,
   input wire        sr_enter_i,
   input wire        pd_enter_i,
   input wire [17:0] base_mode_register_o,
   input wire [17:0] second_mode_register_o,
   input wire [3:0]  cas_read_latency_o,
   input wire [3:0]  write_recovery_o,
   input wire        powerdown_dll_keep_o,
   input wire        dll_running_o,
   input wire        dll_reset_pulse_o,
   input wire        rtt_allowed_o,
   input wire        beat_valid_o,
   input wire        dq_oe_o,
   input wire        dqs_oe_o,
   input wire        burst_busy_o
);
   // One clock domain, so every property shares one clock and one reset.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // The DLL reset bit never reads back as set, so the capture check masks it out.
   a_base_capture: assert property (mrs_i && bank_addr_i == 3'h0
      |=> base_mode_register_o == ($past(addr_i) & 18'h3feff)) else $error("base register capture wrong");
   a_second_capture: assert property (mrs_i && bank_addr_i == 3'h1
      |=> second_mode_register_o == $past(addr_i)) else $error("second register capture wrong");
   a_second_hold: assert property (!mrs_i || bank_addr_i != 3'h1 |=> $stable(second_mode_register_o))
      else $error("second register changed without a write");
   a_dll_pulse: assert property (mrs_i && bank_addr_i == 3'h0 && addr_i[8] |=> dll_reset_pulse_o)
      else $error("no DLL reset pulse");
   a_cl_range: assert property (cas_read_latency_o == 4'h0 || cas_read_latency_o inside {[4'h5:4'he]})
      else $error("latency out of range");
   a_wr_values: assert property (write_recovery_o inside {4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc})
      else $error("write recovery value not supported");
   a_idle_float: assert property (!beat_valid_o |-> !dq_oe_o && !dqs_oe_o)
      else $error("drivers on outside a beat");
   a_qoff_float: assert property (second_mode_register_o[12] |-> !dq_oe_o && !dqs_oe_o)
      else $error("drivers on while outputs disabled");
   a_read_latency: assert property ((read_i || write_i) && !burst_busy_o && cas_read_latency_o == 4'h5
      |=> !beat_valid_o [*5] ##1 beat_valid_o) else $error("first beat at wrong cycle");
   a_sr_stop: assert property (sr_enter_i |=> !dll_running_o) else $error("DLL runs in self refresh");
   a_pd_stop: assert property (pd_enter_i && !powerdown_dll_keep_o |=> !dll_running_o)
      else $error("DLL runs in power-down");
   a_rtt_write: assert property (second_mode_register_o[7] && !second_mode_register_o[12]
      && {second_mode_register_o[9], second_mode_register_o[6], second_mode_register_o[2]} > 3'h3
      |-> !rtt_allowed_o) else $error("termination allowed wrongly");
endmodule // ddmr_chk

bind ddmr_mode_regs ddmr_chk i_ddmr_chk (.*);

// >>> verif/ddmr_ctrl.sv
// Controller model: issues mode-set and burst commands to the mode register block.
// Assumes the block samples on the rising edge of clk_i; the bench calls the tasks.
`timescale 1ns/1ps
`include "ddmr_consts.vh"
module ddmr_ctrl #(
   parameter COL_W = 13,
   parameter GAP   = 4
) (
   input  wire             clk_i,
   output reg              mrs_o,
   output reg  [2:0]       bank_addr_o,
   output reg  [17:0]      addr_o,
   output reg              read_o,
   output reg              write_o,
   output reg  [COL_W-1:0] col_o
);
   // Quiet bus at time zero.
   initial {mrs_o, bank_addr_o, addr_o, read_o, write_o, col_o} = '0;
   // Reserved bits always go out as zero; the released bus shows the inverse, never a stale value.
   task mode_set(input [2:0] ba, input [17:0] v);
      begin
         @(posedge clk_i) #1 mrs_o = 1'b1;
         bank_addr_o = ba;
         addr_o = v & ~(ba == 3'h0 ? `DDMR_BASE_RSV_MASK : ba == 3'h1 ? `DDMR_SEC_RSV_MASK : 18'h0);
         @(posedge clk_i) #1 mrs_o = 1'b0;
         addr_o = ~addr_o;
         repeat (GAP) @(posedge clk_i);
         @(negedge clk_i);
      end
   endtask
   // One-cycle burst command; the chop choice rides on the top column bit.
   task cmd(input rd, input [COL_W-1:0] c);
      begin
         @(posedge clk_i) #1 read_o = rd;
         write_o = !rd;
         col_o = c;
         @(posedge clk_i) #1 read_o = 1'b0;
         write_o = 1'b0;
         col_o = ~c;
      end
   endtask
   // No read may follow a DLL reset before the lock count has run.
   // Returns on the falling edge so that the caller never samples in the launching time step.
   task lock_wait(input integer n);
      begin
         repeat (n) @(posedge clk_i);
         @(negedge clk_i);
      end
   endtask
   // Write recovery code, rounded up so that a fractional cycle never shortens the recovery.
   function [2:0] wr_code(input integer t_ns, input integer tck_ns);
      integer n;
      begin
         n = (t_ns + tck_ns - 1) / tck_ns;
         wr_code = n <= 8 ? n - 4 : n <= 10 ? 3'h5 : 3'h6;
      end
   endfunction
endmodule // ddmr_ctrl

// >>> verif/ddmr_mode_regs_tb.sv
// Testbench for the mode register block: registers, decodes, burst order and DLL control.
// Assumes the controller model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "ddmr_consts.vh"
module ddmr_mode_regs_tb;
   localparam COL_W = 13;
   localparam LOCK  = 16;
   reg              clk_i = 1'b0;
   reg              reset_i = 1'b1;
   reg              sr_enter_i = 1'b0, sr_exit_i = 1'b0, pd_enter_i = 1'b0, pd_exit_i = 1'b0;
   wire             mrs_i, read_i, write_i, burst_order_select_o, powerdown_dll_keep_o, dll_running_o;
   wire             dll_locked_o, dll_reset_pulse_o, rtt_allowed_o, mode_error_o, beat_valid_o;
   wire             beat_is_write_o, dq_oe_o, dqs_oe_o, burst_busy_o;
   wire [2:0]       bank_addr_i;
   wire [17:0]      addr_i, base_mode_register_o, second_mode_register_o;
   wire [3:0]       cas_read_latency_o, write_recovery_o;
   wire [COL_W-1:0] col_i, beat_col_o;
   integer          n_errors = 0, compares = 0, cycles = 0, j;
   ddmr_mode_regs #(.COL_W(COL_W), .LOCK_CYC(LOCK)) i_ddmr_mode_regs (.*);
   ddmr_ctrl #(.COL_W(COL_W)) i_ddmr_ctrl (.clk_i(clk_i), .mrs_o(mrs_i), .bank_addr_o(bank_addr_i),
      .addr_o(addr_i), .read_o(read_i), .write_o(write_i), .col_o(col_i));
   // Free-running 50 MHz clock.
   always #10 clk_i = ~clk_i;
   // The run needs about six hundred cycles; the ceiling leaves ample room.
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         give_verdict;
      end
   end
   // Every comparison is counted; a mismatch is reported at once.
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("Comparisons %0d, mismatches %0d", compares, n_errors);
         if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // One-cycle pulse on self refresh enter, exit, power-down enter or exit.
   task pulse(input [1:0] w);
      begin
         @(posedge clk_i) #1 {sr_enter_i, sr_exit_i, pd_enter_i, pd_exit_i} = 4'h8 >> w;
         @(posedge clk_i) #1 {sr_enter_i, sr_exit_i, pd_enter_i, pd_exit_i} = 4'h0;
         @(negedge clk_i);
      end
   endtask
   // One burst at latency five: checks first-beat timing, all eight slots, columns and drivers.
   task run(input rd, input [COL_W-1:0] c, input bt, input chop, input qoff);
      integer k, i;
      reg [2:0] s, e;
      begin
         s = c[2:0];
         i_ddmr_ctrl.cmd(rd, c);
         k = 0;
         @(negedge clk_i);
         while (beat_valid_o !== 1'b1 && k < 40) begin
            @(negedge clk_i);
            k = k + 1;
         end
         chk(k, 5);
         for (i = 0; i < 8; i = i + 1) begin
            e = !rd ? (chop ? {s[2], i[1:0]} : i[2:0]) : bt ? s ^ i[2:0] : {s[2] ^ i[2], s[1:0] + i[1:0]};
            chk({burst_busy_o, beat_valid_o}, {1'b1, i < 4 || !chop});
            chk({dq_oe_o, dqs_oe_o}, {2{rd && !qoff && (i < 4 || !chop)}});
            if (i < 4 || !chop) chk({beat_is_write_o, beat_col_o[11:0]}, {!rd, c[11:3], e});
            @(negedge clk_i);
         end
         repeat (2) @(posedge clk_i);
      end
   endtask
   // Register capture, bank routing, ignored bank codes and clearing by reset.
   task t_regs;
      begin
         i_ddmr_ctrl.mode_set(3'h0, 18'h3ffff);
         i_ddmr_ctrl.mode_set(3'h1, 18'h3ffff);
         i_ddmr_ctrl.mode_set(3'h2, 18'h00000);
         chk(base_mode_register_o, 18'h3ffff & ~`DDMR_BASE_RSV_MASK & 18'h3feff);
         chk(second_mode_register_o, 18'h3ffff & ~`DDMR_SEC_RSV_MASK);
         chk(mode_error_o, 1);
         @(posedge clk_i) #1 reset_i = 1'b1;
         @(posedge clk_i) #1 reset_i = 1'b0;
         @(negedge clk_i);
         chk(second_mode_register_o, 18'h0);
      end
   endtask
   // Every latency and write recovery code, with order and power-down bits alternating.
   task t_decode;
      begin
         for (j = 1; j < 11; j = j + 1) begin
            i_ddmr_ctrl.mode_set(3'h0, {5'h0, j[1], j[2:0], 2'h0, j[2:0], j[0], j >= 8, 2'h0});
            chk(cas_read_latency_o, j + 4);
            chk(write_recovery_o, j[2:0] == 3'h5 ? 10 : j[2:0] == 3'h0 || j[2:0] > 3'h5 ? 12 : j[2:0] + 4);
            chk({burst_order_select_o, powerdown_dll_keep_o}, {j[0], j[1]});
         end
         // A 130 ns recovery at a 20 ns clock is 6.5 cycles and must be programmed as 7.
         i_ddmr_ctrl.mode_set(3'h0, {6'h0, i_ddmr_ctrl.wr_code(130, 20), 9'h010});
         chk(write_recovery_o, 7);
         chk(mode_error_o, 0);
      end
   endtask
   // All burst modes, both orders, reads and writes; fixed modes get the chop bit set to show it is ignored.
   task t_burst;
      reg [1:0]  m;
      reg [11:0] c;
      begin
         for (j = 0; j < 16; j = j + 1) begin
            m = j[1:0];
            c = 12'h5a0 + j * 3 + 1;
            i_ddmr_ctrl.mode_set(3'h0, {14'h0001, j[2], 1'b0, m == 2'h3, m == 2'h1 || m == 2'h2});
            run(j[3], {m != 2'h1, c}, j[2], m[0], 1'b0);
         end
         i_ddmr_ctrl.mode_set(3'h1, 18'h01000);
         run(1'b1, 13'h1005, 1'b1, 1'b1, 1'b1);
      end
   endtask
   // DLL enable, reset and lock, power-down and self refresh, then termination limits.
   task t_dll;
      begin
         i_ddmr_ctrl.mode_set(3'h1, 18'h00000);
         chk(dll_running_o, 1);
         i_ddmr_ctrl.mode_set(3'h0, 18'h00110);
         chk(dll_locked_o, 0);
         i_ddmr_ctrl.lock_wait(LOCK);
         chk(dll_locked_o, 1);
         pulse(2);
         chk(dll_running_o, 0);
         pulse(3);
         i_ddmr_ctrl.mode_set(3'h0, 18'h01010);
         pulse(2);
         chk(dll_running_o, 1);
         pulse(3);
         pulse(0);
         chk(dll_running_o, 0);
         pulse(1);
         chk({dll_running_o, dll_locked_o}, 2'h2);
         i_ddmr_ctrl.lock_wait(LOCK - 1);
         chk(dll_locked_o, 0);
         i_ddmr_ctrl.lock_wait(1);
         chk(dll_locked_o, 1);
         i_ddmr_ctrl.mode_set(3'h1, 18'h00001);
         pulse(0);
         pulse(1);
         chk(dll_running_o, 0);
         i_ddmr_ctrl.mode_set(3'h1, 18'h00280);
         chk(rtt_allowed_o, 0);
         i_ddmr_ctrl.mode_set(3'h1, 18'h01280);
         chk(rtt_allowed_o, 1);
      end
   endtask
   // Reset for two cycles, then the scenarios in turn.
   initial begin
      repeat (2) @(posedge clk_i);
      #1 reset_i = 1'b0;
      t_regs;
      t_decode;
      t_burst;
      t_dll;
      give_verdict;
   end
endmodule // ddmr_mode_regs_tb
